// *** verilog/lcdovl_pkg.sv ***
// constants shared by both ends of the display-control register link
package lcdovl_pkg;
    // register offsets on the link
    localparam logic [15:0] OFF_CURSOR_SHAPE = 16'h8016;
    localparam logic [15:0] OFF_STEP_DIR     = 16'h8017;
    localparam logic [15:0] OFF_OVERLAY      = 16'h8018;
    localparam logic [15:0] OFF_GLYPH_LO     = 16'h8019;
    localparam logic [15:0] OFF_GLYPH_HI     = 16'h801A;
    localparam logic [15:0] OFF_FINE_SCROLL  = 16'h801B;
    // reset values
    localparam logic [7:0]  RST_BYTE         = 8'h00;
    // field positions
    localparam int          POS_SHAPE        = 7;
    localparam int          POS_THREE_LAYER  = 4;
    localparam int          POS_BLK3_GFX     = 3;
    localparam int          POS_BLK1_GFX     = 2;
    // indirect opcodes
    localparam logic [7:0]  OPC_STEP_RIGHT   = 8'h4C;
    localparam logic [7:0]  OPC_STEP_DOWN    = 8'h4F;
    // controller-side register offsets
    localparam logic [3:0]  CR_ADDR          = 4'h0;
    localparam logic [3:0]  CR_WDATA         = 4'h1;
    localparam logic [3:0]  CR_CTRL          = 4'h2;
    localparam logic [3:0]  CR_STATUS        = 4'h3;
    localparam logic [3:0]  CR_RDATA         = 4'h4;
    // control register bits
    localparam int          CTL_GO           = 0;
    localparam int          CTL_READ         = 1;
    localparam int          CTL_OPCODE       = 2;

    typedef enum logic [1:0] { STEP_RIGHT, STEP_LEFT, STEP_UP, STEP_DOWN } lcdovl_step_t;
    typedef enum logic [1:0] { MIX_OR, MIX_XOR, MIX_AND, MIX_RSVD } lcdovl_mix_t;
endpackage

// *** verilog/lcdovl_if.sv ***
// register link between controller and display register bank
`timescale 1ns/1ps
interface lcdovl_if;
    logic        wr;
    logic        rd;
    logic        op;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    modport dev  (input wr, rd, op, addr, wdata, output rdata);
    modport host (output wr, rd, op, addr, wdata, input rdata);
endinterface

// *** verilog/lcdovl_mixer.sv ***
// per-pixel layer composition with fixed reserved-code fallback
`timescale 1ns/1ps
module lcdovl_mixer
(
    input  wire logic [1:0] i_mix,
    input  wire logic       i_l1,
    input  wire logic       i_l2,
    input  wire logic       i_l3,
    output logic            o_pix
);
    always_comb
    begin
        unique case (lcdovl_pkg::lcdovl_mix_t'(i_mix))
            lcdovl_pkg::MIX_XOR: o_pix = (i_l1 ^ i_l2) | i_l3;
            lcdovl_pkg::MIX_AND: o_pix = (i_l1 & i_l2) | i_l3;
            // reserved code falls back to or to stay deterministic
            default:             o_pix = i_l1 | i_l2 | i_l3;
        endcase
    end
endmodule

// *** verilog/lcdovl_dev.sv ***
// display-control register bank: cursor, step, overlay, glyph base, fine scroll
`timescale 1ns/1ps
module lcdovl_dev
(
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_srst,
    // register link
    lcdovl_if.dev            bus,
    // display memory access and geometry
    input  wire logic        i_mem_access,
    input  wire logic        i_addr_load,
    input  wire logic [15:0] i_addr_value,
    input  wire logic [15:0] i_pitch,
    output logic      [15:0] o_access_addr,
    // glyph lookup
    input  wire logic [7:0]  i_char_code,
    input  wire logic [3:0]  i_char_height_m1,
    output logic      [15:0] o_glyph_addr,
    // layer pixels in, composed pixel out
    input  wire logic        i_blk1_pix,
    input  wire logic        i_blk2_pix,
    input  wire logic        i_blk3_pix,
    input  wire logic        i_blk4_pix,
    input  wire logic        i_blk1_text_pix,
    input  wire logic        i_blk3_text_pix,
    output logic             o_pixel,
    // decoded state
    output logic             o_block_cursor,
    output logic      [3:0]  o_cursor_lines_m1,
    output logic             o_blk1_graphics,
    output logic             o_blk3_graphics,
    output logic             o_three_layers,
    output logic      [2:0]  o_fine_scroll
);
    logic [7:0]  shape_reg;
    logic [1:0]  dir_reg;
    logic [7:0]  ovl_reg;
    logic [15:0] glyph_base_reg;
    logic [2:0]  scroll_reg;
    logic [15:0] addr_reg;
    logic [15:0] glyph_next;
    logic [7:0]  rdata_next;
    logic        l1;
    logic        l2;
    logic        l3;
    logic        mix_pix;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        hit = (a == off);
    endfunction

    // cursor shape register
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            shape_reg <= lcdovl_pkg::RST_BYTE;
        else if (bus.wr && hit(bus.addr, lcdovl_pkg::OFF_CURSOR_SHAPE))
            shape_reg <= bus.wdata & 8'h8F;
    end

    // step direction: register write or indirect opcode 4C-4F
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            dir_reg <= lcdovl_pkg::STEP_RIGHT;
        else if (bus.op && bus.wdata >= lcdovl_pkg::OPC_STEP_RIGHT
                 && bus.wdata <= lcdovl_pkg::OPC_STEP_DOWN)
            dir_reg <= bus.wdata[1:0];
        else if (bus.wr && hit(bus.addr, lcdovl_pkg::OFF_STEP_DIR))
            dir_reg <= bus.wdata[1:0];
    end

    // overlay register
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            ovl_reg <= lcdovl_pkg::RST_BYTE;
        else if (bus.wr && hit(bus.addr, lcdovl_pkg::OFF_OVERLAY))
            ovl_reg <= bus.wdata & 8'h1F;
    end

    // glyph ram base, two bytes
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            glyph_base_reg <= 16'h0000;
        else if (bus.wr && hit(bus.addr, lcdovl_pkg::OFF_GLYPH_LO))
            glyph_base_reg[7:0] <= bus.wdata;
        else if (bus.wr && hit(bus.addr, lcdovl_pkg::OFF_GLYPH_HI))
            glyph_base_reg[15:8] <= bus.wdata;
    end

    // fine scroll
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            scroll_reg <= 3'h0;
        else if (bus.wr && hit(bus.addr, lcdovl_pkg::OFF_FINE_SCROLL))
            scroll_reg <= bus.wdata[2:0];
    end

    // memory access address; steps are raw address units, so 9-pixel glyphs need presetting
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            addr_reg <= 16'h0000;
        else if (i_addr_load)
            addr_reg <= i_addr_value;
        else if (i_mem_access)
        begin
            unique case (lcdovl_pkg::lcdovl_step_t'(dir_reg))
                lcdovl_pkg::STEP_RIGHT: addr_reg <= addr_reg + 16'h0001;
                lcdovl_pkg::STEP_LEFT:  addr_reg <= addr_reg - 16'h0001;
                lcdovl_pkg::STEP_UP:    addr_reg <= addr_reg - i_pitch;
                lcdovl_pkg::STEP_DOWN:  addr_reg <= addr_reg + i_pitch;
            endcase
        end
    end

    // glyph start: code times height plus base
    assign glyph_next = 16'({8'h00, i_char_code} * {12'h000, i_char_height_m1}
                            + {8'h00, i_char_code}) + glyph_base_reg;

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            o_glyph_addr <= 16'h0000;
        else
            o_glyph_addr <= glyph_next;
    end

    // layer assembly: blocks 2 and 4 graphics only, text first layer drops the third
    assign l1 = (ovl_reg[lcdovl_pkg::POS_BLK1_GFX] ? i_blk1_pix : i_blk1_text_pix)
              | (ovl_reg[lcdovl_pkg::POS_BLK3_GFX] ? i_blk3_pix : i_blk3_text_pix);
    assign l2 = i_blk2_pix;
    assign l3 = ovl_reg[lcdovl_pkg::POS_THREE_LAYER] && ovl_reg[lcdovl_pkg::POS_BLK1_GFX]
              && i_blk4_pix;

    // one method for the whole layer, not per block
    lcdovl_mixer u_mix
    (
        .i_mix (ovl_reg[1:0]),
        .i_l1  (l1),
        .i_l2  (l2),
        .i_l3  (l3),
        .o_pix (mix_pix)
    );

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            o_pixel <= 1'b0;
        else
            o_pixel <= mix_pix;
    end

    // read back
    always_comb
    begin
        unique case (bus.addr)
            lcdovl_pkg::OFF_CURSOR_SHAPE: rdata_next = shape_reg;
            lcdovl_pkg::OFF_STEP_DIR:     rdata_next = {6'h00, dir_reg};
            lcdovl_pkg::OFF_OVERLAY:      rdata_next = ovl_reg;
            lcdovl_pkg::OFF_GLYPH_LO:     rdata_next = glyph_base_reg[7:0];
            lcdovl_pkg::OFF_GLYPH_HI:     rdata_next = glyph_base_reg[15:8];
            lcdovl_pkg::OFF_FINE_SCROLL:  rdata_next = {5'h00, scroll_reg};
            default:                      rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            bus.rdata <= 8'h00;
        else if (bus.rd)
            bus.rdata <= rdata_next;
    end

    assign o_access_addr     = addr_reg;
    assign o_block_cursor    = shape_reg[lcdovl_pkg::POS_SHAPE];
    assign o_cursor_lines_m1 = shape_reg[3:0];
    assign o_blk1_graphics   = ovl_reg[lcdovl_pkg::POS_BLK1_GFX];
    assign o_blk3_graphics   = ovl_reg[lcdovl_pkg::POS_BLK3_GFX];
    assign o_three_layers    = ovl_reg[lcdovl_pkg::POS_THREE_LAYER];
    // scroll is a single value for the composed output, never per layer
    assign o_fine_scroll     = scroll_reg;
endmodule

// *** verilog/lcdovl_host.sv ***
// host-side controller driving the register link from software registers
`timescale 1ns/1ps
module lcdovl_host
(
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_srst,
    // software port
    input  wire logic [3:0]  i_sw_addr,
    input  wire logic [15:0] i_sw_wdata,
    input  wire logic        i_sw_wr,
    input  wire logic        i_sw_rd,
    output logic      [15:0] o_sw_rdata,
    // register link
    lcdovl_if.host           bus
);
    logic [15:0] addr_reg;
    logic [7:0]  wdata_reg;
    logic [7:0]  rdata_reg;
    logic        pend_reg;
    logic        wr_reg;
    logic        rd_reg;
    logic        op_reg;

    // software registers; checks on width, height, scroll and row bytes stay with software
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            addr_reg  <= 16'h0000;
            wdata_reg <= 8'h00;
        end
        else if (i_sw_wr && i_sw_addr == lcdovl_pkg::CR_ADDR)
            addr_reg <= i_sw_wdata;
        else if (i_sw_wr && i_sw_addr == lcdovl_pkg::CR_WDATA)
            wdata_reg <= i_sw_wdata[7:0];
    end

    // one link cycle per go
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            op_reg <= 1'b0;
        end
        else
        begin
            wr_reg <= i_sw_wr && i_sw_addr == lcdovl_pkg::CR_CTRL
                      && i_sw_wdata[lcdovl_pkg::CTL_GO] && !i_sw_wdata[lcdovl_pkg::CTL_READ]
                      && !i_sw_wdata[lcdovl_pkg::CTL_OPCODE];
            rd_reg <= i_sw_wr && i_sw_addr == lcdovl_pkg::CR_CTRL
                      && i_sw_wdata[lcdovl_pkg::CTL_GO] && i_sw_wdata[lcdovl_pkg::CTL_READ];
            op_reg <= i_sw_wr && i_sw_addr == lcdovl_pkg::CR_CTRL
                      && i_sw_wdata[lcdovl_pkg::CTL_GO] && !i_sw_wdata[lcdovl_pkg::CTL_READ]
                      && i_sw_wdata[lcdovl_pkg::CTL_OPCODE];
        end
    end

    // read capture: device answers one cycle after the read strobe
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            pend_reg  <= 1'b0;
            rdata_reg <= 8'h00;
        end
        else
        begin
            pend_reg <= rd_reg;
            if (pend_reg)
                rdata_reg <= bus.rdata;
        end
    end

    assign bus.wr    = wr_reg;
    assign bus.rd    = rd_reg;
    assign bus.op    = op_reg;
    assign bus.addr  = addr_reg;
    assign bus.wdata = wdata_reg;

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            o_sw_rdata <= 16'h0000;
        else if (i_sw_rd)
        begin
            unique case (i_sw_addr)
                lcdovl_pkg::CR_ADDR:   o_sw_rdata <= addr_reg;
                lcdovl_pkg::CR_WDATA:  o_sw_rdata <= {8'h00, wdata_reg};
                // busy includes the issue cycle, so software never sees idle too early
                lcdovl_pkg::CR_STATUS: o_sw_rdata <= {15'h0000, rd_reg | pend_reg};
                lcdovl_pkg::CR_RDATA:  o_sw_rdata <= {8'h00, rdata_reg};
                default:               o_sw_rdata <= 16'h0000;
            endcase
        end
    end
endmodule

// *** sim/lcdovl_monitor.sv ***
// concurrent checks on the register link between host controller and register bank
`timescale 1ns/1ps
module lcdovl_monitor
(
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_srst,
    // link signals
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic        i_op,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic [7:0]  i_rdata
);
    logic [7:0] sh_reg [6];
    wire  logic       in_map = i_addr >= 16'h8016 && i_addr <= 16'h801B;
    wire  logic [2:0] idx    = 3'(i_addr - 16'h8016);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);
    // shadow copies tie each readback to the write that caused it; opcode wins over a write
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            sh_reg <= '{default: 8'h00};
        else if (i_op && i_wdata[7:2] == 6'h13)
            sh_reg[1] <= i_wdata;
        else if (i_wr && in_map)
            sh_reg[idx] <= i_wdata;
    end
    property p_shape;
        i_rd && i_addr == 16'h8016 |=> i_rdata == {sh_reg[0][7], 3'h0, sh_reg[0][3:0]};
    endproperty
    a_shape: assert property (p_shape) else $error("shape readback wrong");
    property p_dir;
        i_rd && i_addr == 16'h8017 |=> i_rdata == {6'h00, sh_reg[1][1:0]};
    endproperty
    a_dir: assert property (p_dir) else $error("step direction wrong");
    property p_ovl;
        i_rd && i_addr == 16'h8018 |=> i_rdata == {3'h0, sh_reg[2][4:0]};
    endproperty
    a_ovl: assert property (p_ovl) else $error("overlay readback wrong");
    property p_glo;
        i_rd && i_addr == 16'h8019 |=> i_rdata == sh_reg[3];
    endproperty
    a_glo: assert property (p_glo) else $error("glyph base low wrong");
    property p_ghi;
        i_rd && i_addr == 16'h801A |=> i_rdata == sh_reg[4];
    endproperty
    a_ghi: assert property (p_ghi) else $error("glyph base high wrong");
    property p_scr;
        i_rd && i_addr == 16'h801B |=> i_rdata == {5'h00, sh_reg[5][2:0]};
    endproperty
    a_scr: assert property (p_scr) else $error("fine scroll wrong");
    property p_unmapped;
        i_rd && !in_map |=> i_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_hold;
        !i_rd |=> $stable(i_rdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    c_opcode: cover property (i_op ##[1:16] i_rd);
    c_ovl_wr: cover property (i_wr && i_addr == 16'h8018);
    c_ghi_rd: cover property (i_rd && i_addr == 16'h801A);
    c_rsvd_mix: cover property (i_wr && i_addr == 16'h8018 && i_wdata[1:0] == 2'b11);
endmodule

// *** sim/lcd_cursor_overlay_scroll_regs_tb_top.sv ***
// self-checking bench: host controller and register bank joined by their link
`timescale 1ns/1ps
module lcd_cursor_overlay_scroll_regs_tb_top;
    logic        i_clock, i_srst, sw_wr, sw_rd, mem_acc, addr_ld, o_pixel;
    logic        rd_q = 1'b0;
    logic [3:0]  sw_addr, hm1;
    logic [5:0]  pix;
    logic [7:0]  code;
    logic [15:0] sw_wdata, sw_rdata, addr_val, pitch, o_access_addr, o_glyph_addr;
    logic        o_block_cursor, o_blk1_graphics, o_blk3_graphics, o_three_layers;
    logic [3:0]  o_cursor_lines_m1;
    logic [2:0]  o_fine_scroll;
    logic [15:0] exp_q [$];
    int          n_fail = 0;
    int          checks_done = 0;
    lcdovl_if lcdovl_if_i ();
    lcdovl_host lcdovl_host_i (.i_clock(i_clock), .i_srst(i_srst), .i_sw_addr(sw_addr),
        .i_sw_wdata(sw_wdata), .i_sw_wr(sw_wr), .i_sw_rd(sw_rd), .o_sw_rdata(sw_rdata),
        .bus(lcdovl_if_i.host));
    lcdovl_dev lcdovl_dev_i (.i_clock(i_clock), .i_srst(i_srst), .bus(lcdovl_if_i.dev),
        .i_mem_access(mem_acc), .i_addr_load(addr_ld), .i_addr_value(addr_val),
        .i_pitch(pitch), .o_access_addr(o_access_addr), .i_char_code(code),
        .i_char_height_m1(hm1), .o_glyph_addr(o_glyph_addr), .i_blk1_pix(pix[0]),
        .i_blk2_pix(pix[1]), .i_blk3_pix(pix[4]), .i_blk4_pix(pix[2]),
        .i_blk1_text_pix(pix[3]), .i_blk3_text_pix(pix[5]), .o_pixel(o_pixel),
        .o_block_cursor(o_block_cursor), .o_cursor_lines_m1(o_cursor_lines_m1),
        .o_blk1_graphics(o_blk1_graphics), .o_blk3_graphics(o_blk3_graphics),
        .o_three_layers(o_three_layers), .o_fine_scroll(o_fine_scroll));
    lcdovl_monitor lcdovl_monitor_i (.i_clock(i_clock), .i_srst(i_srst),
        .i_wr(lcdovl_if_i.wr), .i_rd(lcdovl_if_i.rd), .i_op(lcdovl_if_i.op),
        .i_addr(lcdovl_if_i.addr), .i_wdata(lcdovl_if_i.wdata), .i_rdata(lcdovl_if_i.rdata));
    initial
    begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    task automatic tally_and_finish();
        if (n_fail == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic mix(input logic [1:0] m, input logic a, b, c);
        case (m)
            2'b01:   return (a ^ b) | c;
            2'b10:   return (a & b) | c;
            default: return a | b | c;
        endcase
    endfunction
    task automatic sw_wr_t(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clock);
        sw_addr  <= a;
        sw_wdata <= d;
        sw_wr    <= 1'b1;
        @(posedge i_clock);
        sw_wr    <= 1'b0;
    endtask
    // link write, or opcode when opc is set
    task automatic link_wr(input logic [15:0] a, input logic [7:0] d, input logic opc);
        sw_wr_t(lcdovl_pkg::CR_ADDR, a);
        sw_wr_t(lcdovl_pkg::CR_WDATA, {8'h00, d});
        sw_wr_t(lcdovl_pkg::CR_CTRL, {13'h0000, opc, 2'b01});
        repeat (3) @(posedge i_clock);
    endtask
    // link read; the byte is noted here and compared by the watcher
    task automatic link_rd(input logic [15:0] a, input logic [7:0] e);
        sw_wr_t(lcdovl_pkg::CR_ADDR, a);
        sw_wr_t(lcdovl_pkg::CR_CTRL, 16'h0003);
        // busy must already show while the link read is being issued
        sw_addr <= lcdovl_pkg::CR_STATUS;
        sw_rd   <= 1'b1;
        exp_q.push_back(16'h0001);
        @(posedge i_clock);
        sw_rd   <= 1'b0;
        repeat (4) @(posedge i_clock);
        sw_addr <= lcdovl_pkg::CR_RDATA;
        sw_rd   <= 1'b1;
        exp_q.push_back({8'h00, e});
        @(posedge i_clock);
        sw_rd   <= 1'b0;
    endtask
    task automatic step(input logic load, input logic [15:0] v);
        @(posedge i_clock);
        addr_ld  <= load;
        mem_acc  <= !load;
        addr_val <= v;
        @(posedge i_clock);
        addr_ld  <= 1'b0;
        mem_acc  <= 1'b0;
    endtask
    always @(posedge i_clock)
    begin
        rd_q <= sw_rd;
        if (rd_q)
            chk(sw_rdata, exp_q.pop_front());
    end
    initial
    begin
        repeat (40000) @(posedge i_clock);
        n_fail++;
        tally_and_finish();
    end
    initial
    begin
        logic [7:0]  d;
        logic [15:0] a;
        int          k;
        void'($urandom(32'h4D49B5A4));
        {i_srst, sw_wr, sw_rd, mem_acc, addr_ld} = 5'b10000;
        {sw_addr, sw_wdata, addr_val, code, hm1, pix} = '0;
        pitch = 16'($urandom % 200) + 16'h0001;
        repeat (12) @(posedge i_clock);
        i_srst <= 1'b0;
        // cursor width is left at zero, within any glyph width
        for (k = 16'h8015; k <= 16'h801C; k++)
            link_rd(16'(k), 8'h00);
        d = 8'($urandom); // any height fits the 16-line glyph cell
        link_wr(16'h8016, d, 1'b0);
        link_rd(16'h8016, {d[7], 3'h0, d[3:0]});
        chk({11'h0, o_block_cursor, o_cursor_lines_m1}, {11'h0, d[7], d[3:0]});
        for (k = 0; k < 4; k++)
        begin
            if (k[0])
                link_wr(16'h8017, 8'(k), 1'b0);
            else
                link_wr(16'h8017, 8'h4C + 8'(k), 1'b1);
            // outside the step codes, so it must leave the direction alone
            link_wr(16'h8017, 8'h50, 1'b1);
            link_rd(16'h8017, 8'(k));
            a = 16'($urandom);
            step(1'b1, a);
            step(1'b0, 16'h0000);
            #1;
            chk(o_access_addr, k == 0 ? a + 16'h1 : k == 1 ? a - 16'h1 :
                k == 2 ? a - pitch : a + pitch);
        end
        link_wr(16'h8016, 8'h80, 1'b0); // block cursor while graphics blocks run
        for (k = 0; k < 32; k++)
        begin
            link_wr(16'h8018, 8'(k), 1'b0);
            link_rd(16'h8018, 8'(k));
            chk({13'h0, o_three_layers, o_blk3_graphics, o_blk1_graphics},
                {13'h0, 3'(k >> 2)});
            repeat (4)
            begin
                @(posedge i_clock);
                pix <= 6'($urandom);
                @(posedge i_clock);
                #1;
                chk(16'(o_pixel), 16'(mix(2'(k),
                    (k[2] ? pix[0] : pix[3]) | (k[3] ? pix[4] : pix[5]), pix[1],
                    k[4] & k[2] & pix[2])));
            end
        end
        for (k = 0; k < 5; k++)
        begin
            a = k == 0 ? 16'h6000 : 16'($urandom);
            link_wr(16'h8019, a[7:0], 1'b0);
            link_wr(16'h801A, a[15:8], 1'b0);
            link_rd(16'h801A, a[15:8]);
            @(posedge i_clock);
            code <= k == 0 ? 8'h80 : 8'($urandom);
            hm1  <= k == 0 ? 4'h7 : 4'($urandom);
            repeat (2) @(posedge i_clock);
            #1;
            chk(o_glyph_addr, a + 16'(code) * (16'(hm1) + 16'h1));
        end
        d = 8'($urandom % 8);
        link_wr(16'h801B, d, 1'b0); // one bpp and padded rows assumed
        link_rd(16'h801B, d);
        chk({13'h0, o_fine_scroll}, {13'h0, d[2:0]});
        repeat (4) @(posedge i_clock);
        tally_and_finish();
    end
endmodule
